// File: opdec_pkg.sv
// constants and command codes for the serial flash opcode decoder
// Overview of operation
// - 06 sets write enable latch
// - 04 clears write enable latch
// - 05 shifts status register out
// - 01 writes status from following bits when write enable is set
// - 03 normal speed array read
// - 0B fast array read, distinct code
// - 3B dual output read
// - 20 sector erase
// - 52 or D8 block erase, same
// - 60 or C7 chip erase, same
// - 02 page program
// - B9 deep sleep after select release
// - AB wakes or reads signature
// - 9F shifts out identification bytes
// - 90 reads ids after address
// - address 00 maker first, 01 device first
// - 2B reads security register
// - 2F sets security register bit 0 when its data byte is nonzero
`default_nettype none
package opdec_pkg;
  localparam logic [7:0] OP_WEN_C   = 8'h06;
  localparam logic [7:0] OP_WDIS_C  = 8'h04;
  localparam logic [7:0] OP_STRD_C  = 8'h05;
  localparam logic [7:0] OP_STWR_C  = 8'h01;
  localparam logic [7:0] OP_READ_C  = 8'h03;
  localparam logic [7:0] OP_FAST_C  = 8'h0B;
  localparam logic [7:0] OP_DUAL_C  = 8'h3B;
  localparam logic [7:0] OP_SECT_C  = 8'h20;
  localparam logic [7:0] OP_BLKA_C  = 8'h52;
  localparam logic [7:0] OP_BLKB_C  = 8'hD8;
  localparam logic [7:0] OP_CHPA_C  = 8'h60;
  localparam logic [7:0] OP_CHPB_C  = 8'hC7;
  localparam logic [7:0] OP_PROG_C  = 8'h02;
  localparam logic [7:0] OP_SLEEP_C = 8'hB9;
  localparam logic [7:0] OP_WAKE_C  = 8'hAB;
  localparam logic [7:0] OP_IDENT_C = 8'h9F;
  localparam logic [7:0] OP_MKDV_C  = 8'h90;
  localparam logic [7:0] OP_SCRD_C  = 8'h2B;
  localparam logic [7:0] OP_SCWR_C  = 8'h2F;
  // command index, one per decoded action; 9F and 90 share ident, security read and write share misc
  typedef enum logic [3:0] {
    CMD_NONE_E = 4'h0, CMD_WEN_E  = 4'h1, CMD_WDIS_E = 4'h2, CMD_STRD_E = 4'h3,
    CMD_STWR_E = 4'h4, CMD_READ_E = 4'h5, CMD_FAST_E = 4'h6, CMD_DUAL_E = 4'h7,
    CMD_SECT_E = 4'h8, CMD_BLK_E  = 4'h9, CMD_CHIP_E = 4'hA, CMD_PROG_E = 4'hB,
    CMD_SLEEP_E = 4'hC, CMD_WAKE_E = 4'hD, CMD_IDENT_E = 4'hE, CMD_MISC_E = 4'hF
  } cmd_t;
  localparam logic [3:0] OPC_BITS_C   = 4'h8;
  localparam logic [3:0] MKDV_ADDR_C  = 4'h4;  // bytes up to and incl. address byte
  localparam int         VSL_US_C     = 200;
  localparam int         MCLK_MHZ_C   = 50;
  localparam int         VSL_CYC_C    = VSL_US_C * MCLK_MHZ_C;
  localparam logic [7:0] STATUS_RST_C = 8'h00;
endpackage
`default_nettype wire

// File: opdec_top.sv
// serial flash opcode decoder, link side on the serial clock
`timescale 1ns/1ps
`default_nettype none
module opdec_top #(
  parameter int          VSL_CYC = opdec_pkg::VSL_CYC_C,
  parameter logic [7:0]  MAKER_ID = 8'h5A,  // arbitrary value
  parameter logic [7:0]  DEVICE_ID = 8'hA5  // arbitrary value
) (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic sclk_i,
  input  wire logic cs_n_i,
  input  wire logic si_i,
  output var  logic so_o,
  output var  logic so_oe_o,
  output var  logic sio0_o,
  output var  logic sio0_oe_o,
  output var  logic wel_o,
  output var  logic sleep_o,
  output var  logic ready_o,
  output var  logic [3:0] cmd_o,
  output var  logic cmd_stb_o,
  output var  logic [7:0] status_o,
  output var  logic [7:0] secur_o
);
  ////////////////////////////////////////////////////////////////
  // power-up gate on the system clock
  logic [31:0] vsl_cnt_r, vsl_cnt_nxt;
  logic        ready_r, ready_nxt;
  always_comb begin
    vsl_cnt_nxt = vsl_cnt_r;
    ready_nxt   = ready_r;
    if (vsl_cnt_r == 32'(VSL_CYC - 1)) begin
      ready_nxt = 1'b1;
    end else begin
      vsl_cnt_nxt = vsl_cnt_r + 32'h0000_0001;
    end
  end
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      vsl_cnt_r <= 32'h0000_0000;
      ready_r   <= 1'b0;
    end else begin
      vsl_cnt_r <= vsl_cnt_nxt;
      ready_r   <= ready_nxt;
    end
  end
  // ready into the link domain, two flops
  logic rdy_s1_r, rdy_s2_r;
  always_ff @(posedge sclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdy_s1_r <= 1'b0;
      rdy_s2_r <= 1'b0;
    end else begin
      rdy_s1_r <= ready_r;
      rdy_s2_r <= rdy_s1_r;
    end
  end
  ////////////////////////////////////////////////////////////////
  // link side: frame held in reset by chip select high
  function automatic opdec_pkg::cmd_t decode(input logic [7:0] op);
    case (op)
      opdec_pkg::OP_WEN_C:   decode = opdec_pkg::CMD_WEN_E;
      opdec_pkg::OP_WDIS_C:  decode = opdec_pkg::CMD_WDIS_E;
      opdec_pkg::OP_STRD_C:  decode = opdec_pkg::CMD_STRD_E;
      opdec_pkg::OP_STWR_C:  decode = opdec_pkg::CMD_STWR_E;
      opdec_pkg::OP_READ_C:  decode = opdec_pkg::CMD_READ_E;
      opdec_pkg::OP_FAST_C:  decode = opdec_pkg::CMD_FAST_E;
      opdec_pkg::OP_DUAL_C:  decode = opdec_pkg::CMD_DUAL_E;
      opdec_pkg::OP_SECT_C:  decode = opdec_pkg::CMD_SECT_E;
      opdec_pkg::OP_BLKA_C,
      opdec_pkg::OP_BLKB_C:  decode = opdec_pkg::CMD_BLK_E;
      opdec_pkg::OP_CHPA_C,
      opdec_pkg::OP_CHPB_C:  decode = opdec_pkg::CMD_CHIP_E;
      opdec_pkg::OP_PROG_C:  decode = opdec_pkg::CMD_PROG_E;
      opdec_pkg::OP_SLEEP_C: decode = opdec_pkg::CMD_SLEEP_E;
      opdec_pkg::OP_WAKE_C:  decode = opdec_pkg::CMD_WAKE_E;
      opdec_pkg::OP_IDENT_C,
      opdec_pkg::OP_MKDV_C:  decode = opdec_pkg::CMD_IDENT_E;
      opdec_pkg::OP_SCRD_C,
      opdec_pkg::OP_SCWR_C:  decode = opdec_pkg::CMD_MISC_E;
      default:               decode = opdec_pkg::CMD_NONE_E;
    endcase
  endfunction
  logic       frm_rst;
  assign frm_rst = sys_rst_i | cs_n_i;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] op_r, op_nxt;
  logic       opv_r, opv_nxt;
  logic [3:0] byte_r, byte_nxt;
  logic       first_r, first_nxt;
  logic [7:0] sh_in;
  assign sh_in = {sh_r[6:0], si_i};
  always_comb begin
    bit_nxt   = bit_r + 4'h1;
    sh_nxt    = sh_in;
    op_nxt    = op_r;
    opv_nxt   = opv_r;
    byte_nxt  = byte_r;
    first_nxt = first_r;
    if (bit_r == opdec_pkg::OPC_BITS_C - 4'h1) begin
      bit_nxt = 4'h0;
      if (byte_r != 4'hF) byte_nxt = byte_r + 4'h1;
      if (byte_r == 4'h0 && rdy_s2_r) begin
        op_nxt  = sh_in;
        opv_nxt = 1'b1;
      end
      if (op_r == opdec_pkg::OP_MKDV_C && byte_r == opdec_pkg::MKDV_ADDR_C - 4'h1) begin
        first_nxt = sh_in[0];
      end
    end
  end
  always_ff @(posedge sclk_i or posedge frm_rst) begin
    if (frm_rst) begin
      bit_r   <= 4'h0;
      sh_r    <= 8'h00;
      op_r    <= 8'h00;
      opv_r   <= 1'b0;
      byte_r  <= 4'h0;
      first_r <= 1'b0;
    end else begin
      bit_r   <= bit_nxt;
      sh_r    <= sh_nxt;
      op_r    <= op_nxt;
      opv_r   <= opv_nxt;
      byte_r  <= byte_nxt;
      first_r <= first_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////
  // output shifter on falling edge; sources read across domains are quasi-static
  logic [7:0] status_r, status_nxt;
  logic [7:0] secur_r, secur_nxt;
  logic       wel_r, wel_nxt;
  logic [7:0] osrc;
  always_comb begin
    osrc = 8'h00;
    case (op_r)
      opdec_pkg::OP_STRD_C:  osrc = status_r;
      opdec_pkg::OP_SCRD_C:  osrc = secur_r;
      opdec_pkg::OP_IDENT_C: osrc = byte_r[0] ? MAKER_ID : DEVICE_ID;
      opdec_pkg::OP_WAKE_C:  osrc = DEVICE_ID;
      opdec_pkg::OP_MKDV_C:  osrc = (byte_r[0] ^ first_r) ? DEVICE_ID : MAKER_ID;
      default:               osrc = 8'h00;
    endcase
  end
  logic so_r, oe_r;
  always_ff @(negedge sclk_i or posedge frm_rst) begin
    if (frm_rst) begin
      so_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      oe_r <= opv_r && (op_r == opdec_pkg::OP_MKDV_C ? byte_r >= opdec_pkg::MKDV_ADDR_C
                                                     : byte_r != 4'h0) &&
              (op_r == opdec_pkg::OP_STRD_C || op_r == opdec_pkg::OP_SCRD_C ||
               op_r == opdec_pkg::OP_IDENT_C || op_r == opdec_pkg::OP_MKDV_C ||
               op_r == opdec_pkg::OP_WAKE_C);
      so_r <= osrc[3'(7 - bit_r[2:0])];
    end
  end
  assign so_o      = so_r;
  assign so_oe_o   = oe_r;
  assign sio0_o    = 1'b0;
  assign sio0_oe_o = 1'b0;
  ////////////////////////////////////////////////////////////////
  // frame end: capture action at chip select rise, toggle into mclk
  logic [3:0] act_r;
  logic [7:0] dat_r;
  logic       tgl_r;
  logic       wsec_r;
  always_ff @(posedge cs_n_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      act_r  <= 4'h0;
      dat_r  <= 8'h00;
      tgl_r  <= 1'b0;
      wsec_r <= 1'b0;
    end else begin
      act_r  <= opv_r ? 4'(decode(op_r)) : 4'(opdec_pkg::CMD_NONE_E);
      dat_r  <= sh_r;
      tgl_r  <= ~tgl_r;
      wsec_r <= opv_r && (op_r == opdec_pkg::OP_SCWR_C);
    end
  end
  logic t1_r, t2_r, t3_r;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      t1_r <= 1'b0;
      t2_r <= 1'b0;
      t3_r <= 1'b0;
    end else begin
      t1_r <= tgl_r;
      t2_r <= t1_r;
      t3_r <= t2_r;
    end
  end
  logic ev;
  assign ev = t2_r ^ t3_r;
  logic       sleep_r, sleep_nxt;
  logic [3:0] cmd_r, cmd_nxt;
  logic       stb_r, stb_nxt;
  logic       scwr;
  // read and write share the misc index; only the write opcode may set the bit
  assign scwr = wsec_r && (dat_r != 8'h00);
  always_comb begin
    wel_nxt    = wel_r;
    sleep_nxt  = sleep_r;
    status_nxt = status_r;
    secur_nxt  = secur_r;
    cmd_nxt    = cmd_r;
    stb_nxt    = 1'b0;
    if (ev && act_r != 4'(opdec_pkg::CMD_NONE_E)) begin
      cmd_nxt = act_r;
      stb_nxt = 1'b1;
      case (opdec_pkg::cmd_t'(act_r))
        opdec_pkg::CMD_WEN_E:   wel_nxt = 1'b1;
        opdec_pkg::CMD_WDIS_E:  wel_nxt = 1'b0;
        opdec_pkg::CMD_STWR_E:  begin
          if (wel_r) status_nxt = dat_r;
          wel_nxt = 1'b0;
        end
        opdec_pkg::CMD_SECT_E, opdec_pkg::CMD_BLK_E,
        opdec_pkg::CMD_CHIP_E, opdec_pkg::CMD_PROG_E: wel_nxt = 1'b0;
        opdec_pkg::CMD_SLEEP_E: sleep_nxt = 1'b1;
        opdec_pkg::CMD_WAKE_E:  sleep_nxt = 1'b0;
        opdec_pkg::CMD_MISC_E:  if (scwr) secur_nxt = secur_r | 8'h01;
        default: ;
      endcase
    end
  end
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wel_r    <= 1'b0;
      sleep_r  <= 1'b0;
      status_r <= opdec_pkg::STATUS_RST_C;
      secur_r  <= 8'h00;
      cmd_r    <= 4'h0;
      stb_r    <= 1'b0;
    end else begin
      wel_r    <= wel_nxt;
      sleep_r  <= sleep_nxt;
      status_r <= status_nxt;
      secur_r  <= secur_nxt;
      cmd_r    <= cmd_nxt;
      stb_r    <= stb_nxt;
    end
  end
  assign wel_o     = wel_r;
  assign sleep_o   = sleep_r;
  assign ready_o   = ready_r;
  assign cmd_o     = cmd_r;
  assign cmd_stb_o = stb_r;
  assign status_o  = status_r;
  assign secur_o   = secur_r;
  ////////////////////////////////////////////////////////////////
  wel_set_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    stb_r && cmd_r == 4'(opdec_pkg::CMD_WEN_E) |-> wel_r)
    else $error("write enable not set");
  wel_clear_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    stb_r && cmd_r == 4'(opdec_pkg::CMD_WDIS_E) |-> !wel_r)
    else $error("write enable not cleared");
  wel_quiet_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $changed(wel_r) |-> stb_r)
    else $error("write enable moved without a command");
  sleep_enter_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    stb_r && cmd_r == 4'(opdec_pkg::CMD_SLEEP_E) |-> sleep_r)
    else $error("sleep not entered");
  wake_leave_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    stb_r && cmd_r == 4'(opdec_pkg::CMD_WAKE_E) |-> !sleep_r)
    else $error("sleep not left");
  sleep_quiet_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $changed(sleep_r) |-> stb_r)
    else $error("sleep moved without a command");
  ready_hold_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $rose(ready_r) |-> vsl_cnt_r == 32'(VSL_CYC - 1))
    else $error("ready early");
  gate_early_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !ready_r |-> !stb_r)
    else $error("command accepted before ready");
  prog_wel_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    stb_r && cmd_r == 4'(opdec_pkg::CMD_PROG_E) |-> !wel_r)
    else $error("latch kept after program");
  wipe_wel_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    stb_r && (cmd_r == 4'(opdec_pkg::CMD_SECT_E) || cmd_r == 4'(opdec_pkg::CMD_BLK_E) ||
              cmd_r == 4'(opdec_pkg::CMD_CHIP_E)) |-> !wel_r)
    else $error("latch kept after erase");
  stat_keep_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $changed(status_r) |-> $past(wel_r))
    else $error("status written unarmed");
  stwr_wel_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    stb_r && cmd_r == 4'(opdec_pkg::CMD_STWR_E) |-> !wel_r)
    else $error("latch kept after status write");
  secur_write_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $changed(secur_r) |-> stb_r && cmd_r == 4'(opdec_pkg::CMD_MISC_E))
    else $error("security bits moved without a write");
  rd_quiet_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    stb_r && (cmd_r == 4'(opdec_pkg::CMD_READ_E) || cmd_r == 4'(opdec_pkg::CMD_FAST_E) ||
              cmd_r == 4'(opdec_pkg::CMD_DUAL_E)) |-> $stable(wel_r) && $stable(status_r))
    else $error("array read changed state");
  oe_idle_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    cs_n_i |-> !oe_r)
    else $error("serial output driven while deselected");
  strobe_one_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    stb_r |=> !stb_r)
    else $error("strobe too long");
endmodule
`default_nettype wire

// File: spi_host_model.sv
// host side serial controller model driving select, clock and data
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output var  logic cs_n_o,
  output var  logic sclk_o,
  output var  logic si_o,
  input  wire logic so_i
);
  // 12.5 MHz link clock, below the slowest read limit
  localparam time HALF_C = 40;
  // keeps link edges off the system clock edges
  localparam time SKEW_C = 7;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o   = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // clock stands low outside frames; last byte seen on so is returned
  task automatic frame(input logic [7:0] tx[$], input int nrd, output logic [7:0] rd);
    int i;
    int b;
    rd = 8'h00;
    #SKEW_C;
    cs_n_o = 1'b0;
    #HALF_C;
    for (i = 0; i < tx.size() + nrd; i++) begin
      for (b = 7; b >= 0; b--) begin
        si_o = (i < tx.size()) ? tx[i][b] : 1'b0;
        #HALF_C;
        sclk_o = 1'b1;
        rd = {rd[6:0], so_i};
        #HALF_C;
        sclk_o = 1'b0;
      end
    end
    #HALF_C;
    cs_n_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// File: serial_flash_opcode_decoder_bench.sv
// bench comparing the opcode decoder with a behavioural model
`timescale 1ns/1ps
`default_nettype none
module serial_flash_opcode_decoder_bench;
  localparam int         VSL_C    = 20;
  localparam logic [7:0] MAKER_C  = 8'h3C;  // arbitrary value
  localparam logic [7:0] DEVICE_C = 8'hC3;  // arbitrary value
  logic       mclk_i    = 1'b0;
  logic       sys_rst_i = 1'b1;
  wire logic  sclk_w;
  wire logic  cs_n_w;
  wire logic  si_w;
  logic       so_w;
  logic       so_last   = 1'b0;
  logic       so_o, so_oe_o, sio0_o, sio0_oe_o, wel_o, sleep_o, ready_o, cmd_stb_o;
  logic [3:0] cmd_o;
  logic [7:0] status_o, secur_o, rd;
  int         failures = 0, total_checks = 0, cycles = 0;
  int         m_wel = 0, m_sleep = 0, m_status = 0, m_secur = 0;
  logic [7:0] ops [16] = '{8'h06, 8'h04, 8'h06, 8'h20, 8'h06, 8'h52, 8'h06, 8'hD8,
                           8'h06, 8'h60, 8'h06, 8'hC7, 8'h06, 8'h02, 8'h03, 8'h0B};
  opdec_top #(.VSL_CYC(VSL_C), .MAKER_ID(MAKER_C), .DEVICE_ID(DEVICE_C)) u_opdec_top (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk_w), .cs_n_i(cs_n_w),
    .si_i(si_w), .so_o(so_o), .so_oe_o(so_oe_o), .sio0_o(sio0_o), .sio0_oe_o(sio0_oe_o),
    .wel_o(wel_o), .sleep_o(sleep_o), .ready_o(ready_o), .cmd_o(cmd_o),
    .cmd_stb_o(cmd_stb_o), .status_o(status_o), .secur_o(secur_o));
  spi_host_model u_spi_host_model (
    .cs_n_o(cs_n_w), .sclk_o(sclk_w), .si_o(si_w), .so_i(so_w));
  ////////////////////////////////////////////////////////////////////////////
  // released line shows the inverse of its last value, never a stale bit
  assign so_w = (so_oe_o === 1'b1) ? so_o : ~so_last;
  always @(posedge mclk_i) if (so_oe_o === 1'b1) so_last <= so_o;
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures = failures + 1;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [3:0] exp_cmd(input logic [7:0] op);
    case (op)
      8'h06: return 4'h1;
      8'h04: return 4'h2;
      8'h05: return 4'h3;
      8'h01: return 4'h4;
      8'h03: return 4'h5;
      8'h0B: return 4'h6;
      8'h3B: return 4'h7;
      8'h20: return 4'h8;
      8'h52, 8'hD8: return 4'h9;
      8'h60, 8'hC7: return 4'hA;
      8'h02: return 4'hB;
      8'hB9: return 4'hC;
      8'hAB: return 4'hD;
      8'h9F, 8'h90: return 4'hE;
      8'h2B, 8'h2F: return 4'hF;
      default: return 4'h0;
    endcase
  endfunction
  // model update, one frame, then the strobe and every state output except ready
  task automatic do_op(input logic [7:0] tx[$], input int nrd, input logic [7:0] erd);
    logic [7:0] last;
    logic [3:0] ec;
    logic       seen;
    int         n;
    last = tx[tx.size()-1];
    ec = exp_cmd(tx[0]);
    seen = 1'b0;
    case (tx[0])
      8'h06: m_wel = 1;
      8'h04, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h02: m_wel = 0;
      8'h01: begin
        if (m_wel != 0) m_status = last;
        m_wel = 0;
      end
      8'hB9: m_sleep = 1;
      8'hAB: m_sleep = 0;
      8'h2F: if (last != 8'h00) m_secur = m_secur | 1;
      default: ;
    endcase
    u_spi_host_model.frame(tx, nrd, rd);
    if (nrd > 0) check("read", rd, erd);
    for (n = 0; n < 24 && !seen; n++) begin
      @(posedge mclk_i);
      #1;
      seen = (cmd_stb_o === 1'b1);
    end
    check("strobe", 8'(seen), 8'(ec != 4'h0));
    if (ec != 4'h0) check("cmd", 8'(cmd_o), 8'(ec));
    check("wel", 8'(wel_o), 8'(m_wel));
    check("sleep", 8'(sleep_o), 8'(m_sleep));
    check("status", status_o, 8'(m_status));
    check("secur", secur_o, 8'(m_secur));
    check("so_oe", 8'(so_oe_o), 8'h00);
    check("sio0", {6'h00, sio0_oe_o, sio0_o}, 8'h00);
    repeat (4) @(posedge mclk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(26814));
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    repeat (VSL_C - 2) @(posedge mclk_i);
    #1 check("ready", 8'(ready_o), 8'h00);
    repeat (4) @(posedge mclk_i);
    #1 check("ready", 8'(ready_o), 8'h01);
    do_op({8'hFF, 8'h06}, 0, 8'h00);
    foreach (ops[i]) do_op({ops[i]}, 0, 8'h00);
    do_op({8'h3B}, 0, 8'h00);
    do_op({8'hB9}, 0, 8'h00);
    #10_000;
    do_op({8'hAB}, 0, 8'h00);
    do_op({8'hAB, 8'h00, 8'h00, 8'h00}, 1, DEVICE_C);
    do_op({8'h06}, 0, 8'h00);
    do_op({8'h01, 8'($urandom)}, 0, 8'h00);
    do_op({8'h01, 8'h5A}, 0, 8'h00);
    do_op({8'h05}, 1, 8'(m_status));
    do_op({8'h9F}, 1, MAKER_C);
    do_op({8'h90, 8'h00, 8'h00, 8'h00}, 1, MAKER_C);
    do_op({8'h90, 8'h00, 8'h00, 8'h01}, 1, DEVICE_C);
    do_op({8'h2B, 8'hFF}, 0, 8'h00);
    do_op({8'h2F, 8'($urandom) | 8'h01}, 0, 8'h00);
    do_op({8'h2B}, 1, 8'(m_secur));
    end_of_test();
  end
endmodule
`default_nettype wire
